// file: core/adcs_buffer.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcs_cfg.svh"

module adcs_buffer #(
    parameter int W = `ADCS_WORD_W,
    parameter int DEPTH = `ADCS_BUF_DEPTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // fill and drain sides
    adcs_stream_if.snk in_if,
    adcs_stream_if.src out_if
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0] mem_r [DEPTH];
    logic [PW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic push, pop;

    // handshakes and honest full / empty
    assign in_if.ready = (cnt_r != CW'(DEPTH));
    assign out_if.valid = (cnt_r != '0);
    assign out_if.data = mem_r[rd_r];
    assign push = in_if.valid && in_if.ready;
    assign pop = out_if.valid && out_if.ready;

    // pointer and fill level update
    always_comb
    begin
        wr_nxt = wr_r;
        rd_nxt = rd_r;
        cnt_nxt = cnt_r;
        if (push)
            wr_nxt = (wr_r == PW'(DEPTH - 1)) ? '0 : PW'(wr_r + 1'b1);
        if (pop)
            rd_nxt = (rd_r == PW'(DEPTH - 1)) ? '0 : PW'(rd_r + 1'b1);
        if (push && !pop)
            cnt_nxt = CW'(cnt_r + 1'b1);
        else if (pop && !push)
            cnt_nxt = CW'(cnt_r - 1'b1);
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
        if (push)
            mem_r[wr_r] <= in_if.data;
    end
endmodule : adcs_buffer

`default_nettype wire

// file: core/adcs_cfg.svh
`ifndef ADCS_CFG_SVH
`define ADCS_CFG_SVH

// counter and word widths, buffer depth
`define ADCS_CNT_W 17
`define ADCS_WORD_W 16
`define ADCS_CODE_W 12
`define ADCS_BUF_DEPTH 2

// durations in master clock periods
`define ADCS_CONV_CYC 17'h0_0012
`define ADCS_CAL_FULL_CYC 17'h1_e855
`define ADCS_CAL_DAC_CYC 17'h1_b20a
`define ADCS_CAL_OFS_CYC 17'h0_364b

// serial control word fields
`define ADCS_CTL_CONV 1
`define ADCS_CTL_CAL_LSB 2
`define ADCS_CAL_NONE 2'h0
`define ADCS_CAL_FULL 2'h1
`define ADCS_CAL_DAC 2'h2
`define ADCS_CAL_OFS 2'h3

// last bit index of a serial word
`define ADCS_LAST_BIT 5'h0_00f

// pin idle levels {din, frame_n, sclk, cal_req, convert_start_n, mclk}
`define ADCS_PIN_IDLE 6'h12

`endif

// file: core/adcs_pkg.sv
package adcs_pkg;

    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARMED = 2'b01,
        ST_CONV = 2'b10,
        ST_CAL = 2'b11
    } adcs_state_type;

endpackage : adcs_pkg

// file: core/adcs_sequencer.sv
// Summary of operation
// - a conversion lasts exactly eighteen master clock periods.
// - a full self-calibration lasts 125013 master clock periods.
// - an internal DAC plus system full-scale calibration lasts 111114 master clock periods.
// - a system offset calibration lasts 13899 master clock periods.
// - busy rises within 2.5 master clock periods of a calibration request or of convert-start falling.
// - a serial control write with the convert bit set starts a conversion.
// - the serial output is driven only while a frame is active and released when the frame ends.
// - serial output data changes after each serial clock falling edge.
// - the input line turns into an output after a rising edge and back into an input afterwards.
// - busy stays high until conversion or calibration completes, then falls.
`timescale 1ns/1ps
`default_nettype none
`include "adcs_cfg.svh"

module adcs_sequencer
    import adcs_pkg::*;
#(
    parameter logic [`ADCS_CNT_W-1:0] CAL_FULL_CYC = `ADCS_CAL_FULL_CYC,
    parameter logic [`ADCS_CNT_W-1:0] CAL_DAC_CYC = `ADCS_CAL_DAC_CYC,
    parameter logic [`ADCS_CNT_W-1:0] CAL_OFS_CYC = `ADCS_CAL_OFS_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // converter pins
    input wire logic master_clock_in,
    input wire logic convert_start_n,
    input wire logic cal_req,
    output logic busy,
    // converter core result
    input wire logic [`ADCS_CODE_W-1:0] sample_code,
    // serial pins
    input wire logic frame_n,
    input wire logic sclk,
    input wire logic din_in,
    output logic din_out,
    output logic din_oe,
    output logic dout,
    output logic dout_oe
);
    localparam int PN = 6;
    localparam int WW = `ADCS_WORD_W;
    localparam int CW = `ADCS_CNT_W;

    logic [PN-1:0] pin_raw, meta_r, sync_r, hist_r, rise, fall;
    adcs_state_type state_r, state_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt, cal_len_r, cal_len_nxt;
    logic busy_r, busy_nxt, push;
    logic [WW-1:0] rx_r, rx_nxt, tx_r, tx_nxt;
    logic [4:0] bit_r, bit_nxt;
    logic dout_r, dout_nxt, dout_oe_r, dout_oe_nxt;
    logic din_out_r, din_out_nxt, din_oe_r, din_oe_nxt;
    logic wr_conv_r, wr_conv_nxt;
    logic [1:0] wr_cal_r, wr_cal_nxt;
    logic tick, frame_on;

    adcs_stream_if #(.W(WW)) res_in ();
    adcs_stream_if #(.W(WW)) res_out ();

    // two-entry result buffer toward the serial port
    adcs_buffer #(.W(WW), .DEPTH(`ADCS_BUF_DEPTH)) u_buf (
        .core_clk(core_clk),
        .rst(rst),
        .in_if(res_in),
        .out_if(res_out)
    );

    // pin synchronisers, then an edge history stage
    assign pin_raw = {din_in, frame_n, sclk, cal_req, convert_start_n, master_clock_in};
    for (genvar i = 0; i < PN; i++)
    begin : g_sync
        always_ff @(posedge core_clk)
        begin
            if (rst)
            begin
                meta_r[i] <= 1'(`ADCS_PIN_IDLE >> i);
                sync_r[i] <= 1'(`ADCS_PIN_IDLE >> i);
                hist_r[i] <= 1'(`ADCS_PIN_IDLE >> i);
            end
            else
            begin
                meta_r[i] <= pin_raw[i];
                sync_r[i] <= meta_r[i];
                hist_r[i] <= sync_r[i];
            end
        end
    end

    assign rise = sync_r & ~hist_r;
    assign fall = ~sync_r & hist_r;
    assign tick = rise[0];
    assign frame_on = ~sync_r[4];

    assign res_in.data = {{(WW - `ADCS_CODE_W){1'b0}}, sample_code};
    assign res_in.valid = push;

    // conversion and calibration sequencing
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        cal_len_nxt = cal_len_r;
        busy_nxt = busy_r;
        push = 1'b0;
        unique case (state_r)
            ST_IDLE:
            begin
                cnt_nxt = '0;
                if (rise[2])
                begin
                    state_nxt = ST_CAL;
                    cal_len_nxt = CAL_FULL_CYC;
                    busy_nxt = 1'b1;
                end
                else if (wr_cal_r != `ADCS_CAL_NONE)
                begin
                    state_nxt = ST_CAL;
                    unique case (wr_cal_r)
                        `ADCS_CAL_FULL: cal_len_nxt = CAL_FULL_CYC;
                        `ADCS_CAL_DAC: cal_len_nxt = CAL_DAC_CYC;
                        default: cal_len_nxt = CAL_OFS_CYC;
                    endcase
                    busy_nxt = 1'b1;
                end
                else if (fall[1])
                begin
                    state_nxt = ST_ARMED;
                    busy_nxt = 1'b1;
                end
                else if (wr_conv_r)
                begin
                    state_nxt = ST_CONV;
                    busy_nxt = 1'b1;
                end
            end
            ST_ARMED:
            begin
                if (rise[1])
                    state_nxt = ST_CONV;
            end
            ST_CONV:
            begin
                if (cnt_r != `ADCS_CONV_CYC)
                    cnt_nxt = cnt_r + CW'(tick);
                else
                begin
                    push = 1'b1;
                    if (res_in.ready)
                    begin
                        state_nxt = ST_IDLE;
                        busy_nxt = 1'b0;
                    end
                end
            end
            ST_CAL:
            begin
                if (cnt_r != cal_len_r)
                    cnt_nxt = cnt_r + CW'(tick);
                else
                begin
                    state_nxt = ST_IDLE;
                    busy_nxt = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
            cal_len_r <= '0;
            busy_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            cal_len_r <= cal_len_nxt;
            busy_r <= busy_nxt;
        end
    end

    // serial frame, shift and line direction control
    always_comb
    begin
        rx_nxt = rx_r;
        tx_nxt = tx_r;
        bit_nxt = bit_r;
        dout_nxt = dout_r;
        dout_oe_nxt = dout_oe_r;
        din_out_nxt = din_out_r;
        din_oe_nxt = din_oe_r;
        wr_conv_nxt = 1'b0;
        wr_cal_nxt = `ADCS_CAL_NONE;
        res_out.ready = 1'b0;
        if (fall[4])
        begin
            bit_nxt = '0;
            tx_nxt = res_out.valid ? res_out.data : '0;
            res_out.ready = 1'b1;
            dout_nxt = tx_nxt[WW-1];
            din_out_nxt = tx_nxt[WW-1];
            dout_oe_nxt = 1'b1;
        end
        else if (!frame_on)
        begin
            dout_oe_nxt = 1'b0;
            din_oe_nxt = 1'b0;
        end
        else
        begin
            if (rise[3])
            begin
                rx_nxt = {rx_r[WW-2:0], sync_r[5]};
                bit_nxt = bit_r + 5'h0_001;
                din_oe_nxt = (bit_r == `ADCS_LAST_BIT) && !din_oe_r;
                if (bit_r == `ADCS_LAST_BIT)
                begin
                    wr_conv_nxt = rx_nxt[`ADCS_CTL_CONV];
                    wr_cal_nxt = rx_nxt[`ADCS_CTL_CAL_LSB +: 2];
                end
            end
            if (fall[3])
            begin
                tx_nxt = {tx_r[WW-2:0], 1'b0};
                dout_nxt = tx_r[WW-2];
                din_out_nxt = tx_r[WW-2];
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            rx_r <= '0;
            tx_r <= '0;
            bit_r <= '0;
            dout_r <= 1'b0;
            dout_oe_r <= 1'b0;
            din_out_r <= 1'b0;
            din_oe_r <= 1'b0;
            wr_conv_r <= 1'b0;
            wr_cal_r <= `ADCS_CAL_NONE;
        end
        else
        begin
            rx_r <= rx_nxt;
            tx_r <= tx_nxt;
            bit_r <= bit_nxt;
            dout_r <= dout_nxt;
            dout_oe_r <= dout_oe_nxt;
            din_out_r <= din_out_nxt;
            din_oe_r <= din_oe_nxt;
            wr_conv_r <= wr_conv_nxt;
            wr_cal_r <= wr_cal_nxt;
        end
    end

    // registered outputs
    assign busy = busy_r;
    assign dout = dout_r;
    assign dout_oe = dout_oe_r;
    assign din_out = din_out_r;
    assign din_oe = din_oe_r;

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_conv_length: assert property ($fell(busy_r) && $past(state_r) == ST_CONV |-> $past(cnt_r) == 17'h0_0012)
        else $error("conversion did not last eighteen periods");
    a_cal_full_len: assert property (state_r == ST_IDLE && rise[2] |=> cal_len_r == CAL_FULL_CYC)
        else $error("full calibration length wrong");
    a_cal_dac_len: assert property (state_r == ST_IDLE && !rise[2] && wr_cal_r == 2'h2 |=> cal_len_r == CAL_DAC_CYC)
        else $error("dac calibration length wrong");
    a_cal_ofs_len: assert property (state_r == ST_IDLE && !rise[2] && wr_cal_r == 2'h3 |=> cal_len_r == CAL_OFS_CYC)
        else $error("offset calibration length wrong");
    a_busy_on_cal: assert property (state_r == ST_IDLE && rise[2] |-> ##[1:2] busy_r)
        else $error("busy late after calibration request");
    a_soft_start: assert property (state_r == ST_IDLE && wr_conv_r && !rise[2] && wr_cal_r == 2'h0 && !fall[1]
        |=> state_r == ST_CONV && busy_r)
        else $error("serial start ignored");
    a_dout_release: assert property (!frame_on && !fall[4] |=> !dout_oe_r && !din_oe_r)
        else $error("output driven outside frame");
    a_dout_edge: assert property (dout_oe_r && $past(dout_oe_r) && $changed(dout_r) |-> $past(fall[3]))
        else $error("output changed without clock fall");
    a_din_turn: assert property ($rose(din_oe_r) |-> $past(rise[3]) && $past(bit_r) == `ADCS_LAST_BIT)
        else $error("turnaround not after rising edge");
    a_din_back: assert property (din_oe_r && frame_on && rise[3] |=> !din_oe_r)
        else $error("input line not handed back");
    a_busy_hold: assert property (state_r == ST_CONV || state_r == ST_CAL |-> busy_r)
        else $error("busy dropped early");
    a_cal_end: assert property ($fell(busy_r) && $past(state_r) == ST_CAL |-> $past(cnt_r) == $past(cal_len_r))
        else $error("calibration ended early");

    c_pin_conv: cover property (state_r == ST_ARMED ##[1:100] state_r == ST_CONV);
    c_soft_conv: cover property (wr_conv_r ##1 state_r == ST_CONV);
    c_cal_done: cover property ($fell(busy_r) && $past(state_r) == ST_CAL);
    c_turnaround: cover property ($rose(din_oe_r));
endmodule : adcs_sequencer

`default_nettype wire

// file: core/adcs_stream_if.sv
`timescale 1ns/1ps
`default_nettype none

interface adcs_stream_if #(parameter int W = 16);
    logic [W-1:0] data;
    logic valid;
    logic ready;

    // producer side
    modport src (output data, output valid, input ready);
    // consumer side
    modport snk (input data, input valid, output ready);
endinterface : adcs_stream_if

`default_nettype wire

// file: test/adcs_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module adcs_host_model (
    // observed device pins
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic din_oe,
    // frame pins driven by the host
    output logic frame_n,
    output logic sclk,
    output logic host_d
);
    localparam realtime HALF = 62.5;

    // idle levels, serial clock stands still between frames
    initial
    begin
        frame_n = 1'b1;
        sclk = 1'b0;
        host_d = 1'b0;
    end

    // sixteen bit frame plus one extra edge for the turnaround
    task automatic frame(input logic [15:0] wr, output logic [15:0] rd, output logic turn_on,
        output logic turn_off, output logic oe_in, output logic oe_after);
        frame_n = 1'b0;
        // odd offset keeps link edges off the core clock edges
        #101.25;
        oe_in = dout_oe;
        for (int i = 15; i >= 0; i--)
        begin
            // data set a half period before the rise
            host_d = wr[i];
            #HALF;
            sclk = 1'b1;
            // output sampled on the rise
            // released line reads as the inverse
            rd[i] = dout_oe ? dout : ~dout;
            #HALF;
            // let go of the line after the last rise, data held past it
            if (i == 0)
            begin
                turn_on = din_oe;
                host_d = ~host_d;
            end
            sclk = 1'b0;
        end
        #HALF;
        sclk = 1'b1;
        #HALF;
        turn_off = din_oe;
        sclk = 1'b0;
        #HALF;
        frame_n = 1'b1;
        // whole frame is a multiple of the core period
        #101.25;
        oe_after = dout_oe;
    endtask : frame
endmodule : adcs_host_model

`default_nettype wire

// file: test/tb_adcs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

module tb_adcs_sequencer;
    import adcs_pkg::*;

    // bench signals
    logic core_clk;
    logic rst;
    logic master_clock_in;
    logic convert_start_n;
    logic cal_req;
    logic busy;
    logic [11:0] sample_code;
    logic frame_n;
    logic sclk;
    logic host_d;
    logic din_in;
    logic din_out;
    logic din_oe;
    logic dout;
    logic dout_oe;
    logic [15:0] rd;
    logic t_on;
    logic t_off;
    logic oe_in;
    logic oe_after;
    int fail_count;
    int checks;

    // input line level from both drivers
    assign din_in = (din_oe === 1'b1) ? din_out : host_d;

    adcs_sequencer #(
        .CAL_FULL_CYC(17'h0_0028),
        .CAL_DAC_CYC(17'h0_001e),
        .CAL_OFS_CYC(17'h0_0014)
    ) i_dut (
        .core_clk(core_clk), .rst(rst), .master_clock_in(master_clock_in),
        .convert_start_n(convert_start_n), .cal_req(cal_req), .busy(busy),
        .sample_code(sample_code), .frame_n(frame_n), .sclk(sclk), .din_in(din_in),
        .din_out(din_out), .din_oe(din_oe), .dout(dout), .dout_oe(dout_oe)
    );

    adcs_host_model i_host (
        .dout(dout), .dout_oe(dout_oe), .din_oe(din_oe),
        .frame_n(frame_n), .sclk(sclk), .host_d(host_d)
    );

    // 100 MHz core clock
    always #5 core_clk = ~core_clk;

    // compare and count
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    // bounded wait for a busy level
    task automatic wait_busy(input logic lvl, input int lim);
        int n;
        n = 0;
        while (busy !== lvl && n < lim)
        begin
            @(negedge core_clk);
            n++;
        end
        check("busy level", 16'(busy), 16'(lvl));
        if (busy !== lvl)
            tally_and_finish();
    endtask : wait_busy

    // master clock periods of eight core cycles
    task automatic mtick(input int n);
        repeat (n)
        begin
            @(negedge core_clk) master_clock_in = 1'b1;
            repeat (4) @(negedge core_clk);
            master_clock_in = 1'b0;
            repeat (3) @(negedge core_clk);
        end
    endtask : mtick

    // read one buffered result with turnaround
    task automatic sc_read(input logic [15:0] exp);
        i_host.frame(16'h0000, rd, t_on, t_off, oe_in, oe_after);
        check("read word", rd, exp);
        check("din turned out", 16'(t_on), 16'h0001);
        check("din turned back", 16'(t_off), 16'h0000);
        check("dout in frame", 16'(oe_in), 16'h0001);
        check("dout after frame", 16'(oe_after), 16'h0000);
    endtask : sc_read

    // one conversion by pin or by control word
    task automatic sc_conv(input logic [11:0] code, input logic by_serial, input logic stall);
        @(negedge core_clk);
        sample_code = code;
        if (by_serial)
        begin
            i_host.frame(16'h0002, rd, t_on, t_off, oe_in, oe_after);
            wait_busy(1'b1, 20);
        end
        else
        begin
            convert_start_n = 1'b0;
            wait_busy(1'b1, 20);
            repeat (10) @(negedge core_clk);
            convert_start_n = 1'b1;
        end
        repeat (6) @(negedge core_clk);
        mtick(17);
        check("busy before last period", 16'(busy), 16'h0001);
        mtick(1);
        if (stall)
        begin
            repeat (12) @(negedge core_clk);
            check("busy held while full", 16'(busy), 16'h0001);
        end
        else
            wait_busy(1'b0, 12);
        repeat (40) @(negedge core_clk);
    endtask : sc_conv

    // one calibration by pin or by control word
    task automatic sc_cal(input logic [1:0] kind, input int len, input logic by_pin);
        if (by_pin)
        begin
            @(negedge core_clk) cal_req = 1'b1;
            wait_busy(1'b1, 20);
            cal_req = 1'b0;
        end
        else
            i_host.frame({12'h000, kind, 2'b00}, rd, t_on, t_off, oe_in, oe_after);
        wait_busy(1'b1, 20);
        mtick(len - 1);
        check("busy during calibration", 16'(busy), 16'h0001);
        mtick(1);
        wait_busy(1'b0, 12);
        repeat (40) @(negedge core_clk);
    endtask : sc_cal

    // main sequence
    initial
    begin
        core_clk = 1'b0;
        rst = 1'b1;
        master_clock_in = 1'b0;
        convert_start_n = 1'b1;
        cal_req = 1'b0;
        sample_code = 12'h000;
        fail_count = 0;
        checks = 0;
        repeat (4) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        check("busy after reset", 16'(busy), 16'h0000);
        check("dout idle", 16'(dout_oe), 16'h0000);
        check("din idle", 16'(din_oe), 16'h0000);
        sc_conv(12'ha5c, 1'b0, 1'b0);
        sc_read(16'h0a5c);
        sc_conv(12'h123, 1'b1, 1'b0);
        sc_conv(12'hfed, 1'b0, 1'b0);
        sc_conv(12'h777, 1'b0, 1'b1);
        sc_read(16'h0123);
        wait_busy(1'b0, 20);
        sc_read(16'h0fed);
        sc_read(16'h0777);
        sc_read(16'h0000);
        sc_cal(2'h1, 40, 1'b1);
        sc_cal(2'h1, 40, 1'b0);
        sc_cal(2'h2, 30, 1'b0);
        sc_cal(2'h3, 20, 1'b0);
        tally_and_finish();
    end

    // cut a hang short
    initial
    begin
        #200_000;
        fail_count++;
        tally_and_finish();
    end
endmodule : tb_adcs_sequencer

`default_nettype wire
